// >>> inc/sfa_pkg.sv
`default_nettype none
package sfa_pkg;
	// register offsets on the plain register port
	localparam logic [7:0] CCR_OFS = 8'h00;
	localparam logic [7:0] SYSCFG_OFS = 8'h04;
	localparam logic [7:0] RAMCTL_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0c;
	// condition_flags_register field positions
	localparam int S_POS = 15;
	localparam int MV_POS = 14;
	localparam int H_POS = 13;
	localparam int EV_POS = 12;
	localparam int N_POS = 11;
	localparam int Z_POS = 10;
	localparam int V_POS = 9;
	localparam int C_POS = 8;
	localparam int INT_LSB = 5;
	localparam int SM_POS = 4;
	localparam int PK_LSB = 0;
	// reset values
	localparam logic [15:0] CCR_RST = 16'h00e0;
	localparam logic [15:0] SYSCFG_RST = 16'h8000;
	localparam logic [15:0] RAMCTL_RST = 16'h0000;
	// system_integration_config_reg and ram control fields
	localparam int MM_POS = 15;
	localparam int RAMEN_POS = 0;
	localparam int RAMBASE_LSB = 7;
	// address map
	localparam logic [23:0] INACC_LO = 24'h080000;
	localparam logic [23:0] INACC_HI = 24'hf7ffff;
	localparam logic [2:0] MOD_NIB_LOW = 3'b111;
	localparam logic [7:0] MOD_MID = 8'hff;
	// saturation values
	localparam logic [15:0] SAT_POS_VAL = 16'h7fff;
	localparam logic [15:0] SAT_NEG_VAL = 16'h8000;
	// arithmetic operations
	typedef enum logic [3:0] {
		OP_ADD = 4'h0,
		OP_ADC = 4'h1,
		OP_SUB = 4'h2,
		OP_SBC = 4'h3,
		OP_BCDADD = 4'h4,
		OP_ASL = 4'h5,
		OP_ROL = 4'h6,
		OP_LSR = 4'h7,
		OP_ROR = 4'h8
	} sfa_op_t;
	// bus sequencer states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_OP1 = 2'b01,
		BUS_OP2 = 2'b10,
		BUS_FIN = 2'b11
	} sfa_bus_t;
endpackage
`default_nettype wire

// >>> core/sfa_mac.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_mac (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic mac_clear,
	input wire logic mac_step,
	input wire logic [15:0] mul_h,
	input wire logic [15:0] mul_i,
	input wire logic sat_on,
	input wire logic ovf_seen,
	input wire logic xfer_round,
	output logic [15:0] xfer_data,
	output logic ev_set,
	output logic mv_set
);
	import sfa_pkg::*;
	logic [35:0] acc_reg; // mac_accumulator
	logic presign_reg; // sign held from before the first overflow
	// signed fraction product, shifted once to drop the duplicate sign bit;
	// the shift keeps the product's own sign so that -1 times -1 lands as +1
	// in the guard bits instead of wrapping negative
	wire signed [31:0] prod = $signed(mul_h) * $signed(mul_i);
	wire [35:0] addend = {{3{prod[31]}}, prod, 1'b0}; // [RULE18]
	wire [35:0] sum = acc_reg + addend;
	wire [15:0] rnd = acc_reg[31:16] + {15'h0000, acc_reg[15]};
	// overflow into the sign bit of the whole accumulator
	assign mv_set = mac_step && (acc_reg[35] == addend[35]) && (sum[35] != acc_reg[35]); // [RULE8]
	// extension bits in use: bits 35..31 no longer all equal
	assign ev_set = mac_step && (sum[35:31] != 5'h1f) && (sum[35:31] != 5'h00); // [RULE10]
	// saturated transfer uses the sign from before overflow
	assign xfer_data = (sat_on && ovf_seen) ? (presign_reg ? SAT_NEG_VAL : SAT_POS_VAL) : // [RULE15]
		(xfer_round ? rnd : acc_reg[31:16]);
	// accumulate, clear wins over step
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_reg <= 36'h000000000;
			presign_reg <= 1'b0;
		end else if (mac_clear) begin
			acc_reg <= 36'h000000000;
		end else if (mac_step) begin
			acc_reg <= sum; // [RULE18]
			if ((ev_set || mv_set) && !ovf_seen) begin
				presign_reg <= acc_reg[35];
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/sfa_core.sv
// Notes on behaviour
// [RULE1] upper four address lines copy bit 19
// [RULE2] 080000 to f7ffff reaches nothing
// [RULE3] reset leaves ram disabled
// [RULE4] unimplemented blocks go to external bus
// [RULE5] register block nibble is map bit plus 111
// [RULE6] cleared map bit hides modules until reset
// [RULE7] stop bit: 0 halts clock, 1 nop
// [RULE8] accumulator sign overflow sets m overflow flag
// [RULE9] bcd carry from bit 3 sets half carry
// [RULE10] overflow into bit 31 sets extension flag
// [RULE11] n is result msb, z all zero
// [RULE12] signed overflow sets v
// [RULE13] carry holds carry, borrow, shifted bit
// [RULE14] three-bit mask sets priority level
// [RULE15] saturate on overflow during mac transfers
// [RULE16] bank field prefixes pc, 20 bits
// [RULE17] flag byte order 15 down to 8
// [RULE18] signed fraction product into 36-bit accumulator
// [RULE19] fetches are word aligned
// [RULE20] word is two bytes at lower address
// [RULE21] odd word becomes two byte operations
// [RULE22] lower address byte is high half
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sfa_core (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic alu_go,
	input wire sfa_pkg::sfa_op_t alu_op,
	input wire logic [15:0] op_a,
	input wire logic [15:0] op_b,
	output logic [15:0] alu_result,
	input wire logic mac_clear,
	input wire logic mac_step,
	input wire logic [15:0] mul_h,
	input wire logic [15:0] mul_i,
	input wire logic xfer_req,
	input wire logic xfer_round,
	output logic [15:0] xfer_out,
	input wire logic sleep_req,
	input wire logic wake_req,
	output logic clk_halt,
	output logic [2:0] irq_level,
	input wire logic fetch_req,
	input wire logic [15:0] pc,
	output logic [19:0] fetch_addr,
	input wire logic acc_req,
	input wire logic [19:0] acc_addr,
	input wire logic acc_word,
	input wire logic acc_wr,
	input wire logic [15:0] acc_wdata,
	output logic acc_done,
	output logic acc_err,
	output logic [15:0] acc_rdata,
	output logic [23:0] bus_addr,
	output logic bus_strobe,
	output logic bus_wr,
	output logic bus_word,
	output logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	output logic sel_modreg,
	output logic sel_ram,
	output logic sel_ext
);
	import sfa_pkg::*;

	// software visible state
	logic [15:0] ccr_reg; // condition_flags_register
	logic [15:0] ccr_next;
	logic mm_reg; // module_map_bit
	logic ram_en_reg; // ram array enable
	logic [8:0] ram_base_reg; // ram base, 2 KB aligned
	logic err_reg; // last access hit the dead region

	// arithmetic outputs
	logic [15:0] alu_res;
	logic alu_c;
	logic alu_v;
	logic alu_h;
	logic alu_byte;

	// bus sequencer state
	sfa_bus_t state_reg;
	sfa_bus_t state_next;
	logic [19:0] hold_addr_reg; // request address
	logic hold_word_reg;
	logic hold_wr_reg;
	logic [15:0] hold_wdata_reg;
	logic hold_split_reg; // odd word, two byte operations
	logic [7:0] hi_byte_reg; // first byte of a split read

	// mac
	logic [15:0] mac_data;
	logic mac_ev;
	logic mac_mv;

	// register write decodes
	wire wr_ccr = reg_wr && (reg_addr == CCR_OFS);
	wire wr_cfg = reg_wr && (reg_addr == SYSCFG_OFS);
	wire wr_ram = reg_wr && (reg_addr == RAMCTL_OFS);

	// carry in for chained add and subtract
	wire cin = ccr_reg[C_POS] && (alu_op == OP_ADC || alu_op == OP_SBC);
	wire [16:0] add_sum = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, cin};
	wire [16:0] sub_dif = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, cin};
	wire [8:0] byte_sum = {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]};
	wire [4:0] nib_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};

	// arithmetic and shift datapath, byte op only for bcd add
	always_comb begin
		alu_res = 16'h0000;
		alu_c = 1'b0;
		alu_v = 1'b0;
		alu_h = 1'b0;
		alu_byte = 1'b0;
		unique case (alu_op)
			OP_ADD, OP_ADC: begin
				alu_res = add_sum[15:0];
				alu_c = add_sum[16]; // [RULE13]
				alu_v = (op_a[15] == op_b[15]) && (add_sum[15] != op_a[15]); // [RULE12]
			end
			OP_SUB, OP_SBC: begin
				alu_res = sub_dif[15:0];
				alu_c = sub_dif[16]; // [RULE13]
				alu_v = (op_a[15] != op_b[15]) && (sub_dif[15] != op_a[15]); // [RULE12]
			end
			OP_BCDADD: begin
				alu_byte = 1'b1;
				alu_res = {8'h00, byte_sum[7:0]};
				alu_c = byte_sum[8];
				alu_h = nib_sum[4]; // [RULE9]
				alu_v = (op_a[7] == op_b[7]) && (byte_sum[7] != op_a[7]);
			end
			OP_ASL: begin
				alu_res = {op_a[14:0], 1'b0};
				alu_c = op_a[15]; // [RULE13]
				alu_v = op_a[15] ^ op_a[14];
			end
			OP_ROL: begin
				alu_res = {op_a[14:0], ccr_reg[C_POS]}; // [RULE13]
				alu_c = op_a[15];
				alu_v = op_a[15] ^ op_a[14];
			end
			OP_LSR: begin
				alu_res = {1'b0, op_a[15:1]};
				alu_c = op_a[0]; // [RULE13]
				alu_v = op_a[0];
			end
			OP_ROR: begin
				alu_res = {ccr_reg[C_POS], op_a[15:1]}; // [RULE13]
				alu_c = op_a[0];
				alu_v = ccr_reg[C_POS] ^ op_a[0];
			end
			default: begin
				alu_res = op_a;
			end
		endcase
	end

	// n and z follow the width of the result
	wire alu_n = alu_byte ? alu_res[7] : alu_res[15]; // [RULE11]
	wire alu_z = alu_byte ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000); // [RULE11]

	// software write first, then hardware events; a mac overflow flag set wins over a clear
	wire [15:0] ccr_sw = wr_ccr ? reg_wdata : ccr_reg;
	wire ovf_seen = ccr_reg[EV_POS] || ccr_reg[MV_POS];
	always_comb begin
		ccr_next = ccr_sw;
		ccr_next[MV_POS] = ccr_sw[MV_POS] || mac_mv; // [RULE8]
		ccr_next[EV_POS] = ccr_sw[EV_POS] || mac_ev; // [RULE10]
		if (alu_go) begin
			ccr_next[N_POS] = alu_n; // [RULE17]
			ccr_next[Z_POS] = alu_z;
			ccr_next[V_POS] = alu_v;
			ccr_next[C_POS] = alu_c;
			if (alu_byte) begin
				ccr_next[H_POS] = alu_h; // [RULE9]
			end
		end
	end

	// the mac unit with its saturating transfer path
	sfa_mac u_mac (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.mac_clear(mac_clear),
		.mac_step(mac_step),
		.mul_h(mul_h),
		.mul_i(mul_i),
		.sat_on(ccr_reg[SM_POS]),
		.ovf_seen(ovf_seen),
		.xfer_round(xfer_round),
		.xfer_data(mac_data),
		.ev_set(mac_ev),
		.mv_set(mac_mv)
	);

	// address of the operation about to be issued
	wire [19:0] op_addr = (state_reg == BUS_IDLE) ? acc_addr : (hold_addr_reg + 20'h00001);
	wire [23:0] mir_addr = {{4{op_addr[19]}}, op_addr}; // [RULE1]
	wire hit_inacc = (mir_addr >= INACC_LO) && (mir_addr <= INACC_HI); // [RULE2]
	// modules only answer at nibble m111, and only while the map bit stands
	wire hit_mod = mm_reg && (mir_addr[23:20] == {mm_reg, MOD_NIB_LOW}) && // [RULE5]
		(mir_addr[19:12] == MOD_MID);
	wire hit_ram = ram_en_reg && (mir_addr[19:11] == ram_base_reg) && !hit_mod; // [RULE3]
	wire hit_ext = !hit_inacc && !hit_mod && !hit_ram; // [RULE4]
	// an odd word splits; a word otherwise sits at its lower byte
	wire req_split = acc_word && acc_addr[0]; // [RULE21]

	// sequencer: one strobe for bytes and aligned words, two for odd words
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BUS_IDLE: begin
				if (acc_req) begin
					state_next = BUS_OP1;
				end
			end
			BUS_OP1: begin
				state_next = hold_split_reg ? BUS_OP2 : BUS_FIN; // [RULE21]
			end
			BUS_OP2: begin
				state_next = BUS_FIN;
			end
			BUS_FIN: begin
				state_next = BUS_IDLE;
			end
		endcase
	end
	wire issue = (state_reg == BUS_IDLE && acc_req) || (state_reg == BUS_OP1 && hold_split_reg);
	wire first_op = (state_reg == BUS_IDLE);
	// byte lane for split operations: high half goes first
	wire [15:0] op_wdata = first_op ? (req_split ? {8'h00, acc_wdata[15:8]} : acc_wdata) : // [RULE22]
		{8'h00, hold_wdata_reg[7:0]};

	// register block and flags
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ccr_reg <= CCR_RST;
			mm_reg <= SYSCFG_RST[MM_POS];
			ram_en_reg <= RAMCTL_RST[RAMEN_POS]; // [RULE3]
			ram_base_reg <= RAMCTL_RST[RAMBASE_LSB +: 9];
		end else begin
			ccr_reg <= ccr_next;
			// the map bit can only be cleared; setting it again takes a reset
			if (wr_cfg && !reg_wdata[MM_POS]) begin
				mm_reg <= 1'b0; // [RULE6]
			end
			if (wr_ram) begin
				ram_en_reg <= reg_wdata[RAMEN_POS];
				ram_base_reg <= reg_wdata[RAMBASE_LSB +: 9];
			end
		end
	end

	// register read data, one cycle after the strobe
	wire [15:0] rd_mux = (reg_addr == CCR_OFS) ? ccr_reg :
		(reg_addr == SYSCFG_OFS) ? {mm_reg, 15'h0000} :
		(reg_addr == RAMCTL_OFS) ? {ram_base_reg, 6'h00, ram_en_reg} :
		(reg_addr == STAT_OFS) ? {13'h0000, clk_halt, err_reg, state_reg != BUS_IDLE} :
		16'h0000;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// datapath outputs, priority level and fetch address
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			alu_result <= 16'h0000;
			xfer_out <= 16'h0000;
			irq_level <= CCR_RST[INT_LSB +: 3];
			fetch_addr <= 20'h00000;
			clk_halt <= 1'b0;
		end else begin
			if (alu_go) begin
				alu_result <= alu_res;
			end
			if (xfer_req) begin
				xfer_out <= mac_data; // [RULE15]
			end
			irq_level <= ccr_reg[INT_LSB +: 3]; // [RULE14]
			if (fetch_req) begin
				// bank field on top of the pc, bit 0 forced low
				fetch_addr <= {ccr_reg[PK_LSB +: 4], pc[15:1], 1'b0}; // [RULE16] [RULE19]
			end
			// stop bit clear halts; set makes the sleep a no-op
			if (sleep_req && !ccr_reg[S_POS]) begin
				clk_halt <= 1'b1; // [RULE7]
			end else if (wake_req) begin
				clk_halt <= 1'b0;
			end
		end
	end

	// sequencer state and request hold
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= BUS_IDLE;
			hold_addr_reg <= 20'h00000;
			hold_word_reg <= 1'b0;
			hold_wr_reg <= 1'b0;
			hold_wdata_reg <= 16'h0000;
			hold_split_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (first_op && acc_req) begin
				hold_addr_reg <= acc_addr; // [RULE20]
				hold_word_reg <= acc_word;
				hold_wr_reg <= acc_wr;
				hold_wdata_reg <= acc_wdata;
				hold_split_reg <= req_split;
			end
		end
	end

	// bus drive: dead-region accesses raise no strobe and no select
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_addr <= 24'h000000;
			bus_strobe <= 1'b0;
			bus_wr <= 1'b0;
			bus_word <= 1'b0;
			bus_wdata <= 16'h0000;
			sel_modreg <= 1'b0;
			sel_ram <= 1'b0;
			sel_ext <= 1'b0;
		end else begin
			bus_strobe <= issue && !hit_inacc; // [RULE2]
			sel_modreg <= issue && hit_mod;
			sel_ram <= issue && hit_ram;
			sel_ext <= issue && hit_ext; // [RULE4]
			if (issue) begin
				bus_addr <= mir_addr; // [RULE1]
				bus_wr <= first_op ? acc_wr : hold_wr_reg;
				bus_word <= first_op && acc_word && !req_split; // [RULE21]
				bus_wdata <= op_wdata;
			end
		end
	end

	// read capture and completion
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_byte_reg <= 8'h00;
			acc_rdata <= 16'h0000;
			acc_done <= 1'b0;
			acc_err <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			acc_done <= (state_reg == BUS_FIN);
			if (state_reg == BUS_OP2) begin
				hi_byte_reg <= bus_rdata[7:0]; // [RULE22]
			end
			if (issue) begin
				err_reg <= first_op ? hit_inacc : (err_reg || hit_inacc);
			end
			if (state_reg == BUS_FIN) begin
				acc_err <= err_reg;
				if (hold_split_reg) begin
					acc_rdata <= {hi_byte_reg, bus_rdata[7:0]}; // [RULE22]
				end else begin
					acc_rdata <= hold_word_reg ? bus_rdata : {8'h00, bus_rdata[7:0]};
				end
			end else begin
				acc_err <= 1'b0;
			end
		end
	end

	// checks
	property p_mirror;
		@(posedge core_clk) disable iff (!reset_n)
		bus_strobe |-> (bus_addr[23:20] == {4{bus_addr[19]}});
	endproperty
	a_mirror: assert property (p_mirror) else $error("upper address lines differ from bit 19"); // [RULE1]

	property p_dead;
		@(posedge core_clk) disable iff (!reset_n)
		(bus_addr >= INACC_LO && bus_addr <= INACC_HI) |-> !(bus_strobe || sel_ram || sel_modreg);
	endproperty
	a_dead: assert property (p_dead) else $error("dead region was served"); // [RULE2]

	property p_ram_off;
		@(posedge core_clk) disable iff (!reset_n)
		!ram_en_reg |=> !sel_ram;
	endproperty
	a_ram_off: assert property (p_ram_off) else $error("ram selected while disabled"); // [RULE3]

	property p_ext;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(bus_strobe) && !sel_ram && !sel_modreg |-> sel_ext;
	endproperty
	a_ext: assert property (p_ext) else $error("unmapped block not sent outside"); // [RULE4]

	property p_modnib;
		@(posedge core_clk) disable iff (!reset_n)
		sel_modreg |-> (bus_addr[23:20] == 4'hf) && $past(mm_reg);
	endproperty
	a_modnib: assert property (p_modnib) else $error("module block nibble wrong"); // [RULE5]

	property p_mm_sticky;
		@(posedge core_clk) disable iff (!reset_n)
		!mm_reg |=> !mm_reg && !sel_modreg;
	endproperty
	a_mm_sticky: assert property (p_mm_sticky) else $error("modules back before reset"); // [RULE6]

	property p_stop;
		@(posedge core_clk) disable iff (!reset_n)
		sleep_req && !ccr_reg[S_POS] |=> clk_halt;
	endproperty
	a_stop: assert property (p_stop) else $error("sleep did not halt the clock"); // [RULE7]

	property p_fetch;
		@(posedge core_clk) disable iff (!reset_n)
		fetch_req |=> fetch_addr == {$past(ccr_reg[3:0]), $past(pc[15:1]), 1'b0};
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address wrong"); // [RULE16] [RULE19]

	property p_split;
		@(posedge core_clk) disable iff (!reset_n)
		(state_reg == BUS_IDLE) && acc_req && acc_word && acc_addr[0] &&
		!(acc_addr >= INACC_LO[19:0] && acc_addr[19] == 1'b0 && 1'b0)
		|=> bus_strobe && !bus_word ##1 bus_strobe && !bus_word ##1 !bus_strobe ##1 acc_done;
	endproperty
	a_split: assert property (p_split) else $error("odd word not split in two"); // [RULE21]

	property p_level;
		@(posedge core_clk) disable iff (!reset_n)
		##1 irq_level == $past(ccr_reg[7:5]);
	endproperty
	a_level: assert property (p_level) else $error("priority level mismatch"); // [RULE14]

	property p_zero;
		@(posedge core_clk) disable iff (!reset_n)
		alu_go && !alu_byte && !wr_ccr |=> ccr_reg[Z_POS] == (alu_result == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag disagrees with result"); // [RULE11]
endmodule
`default_nettype wire

// >>> verif/sfa_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for every target on the bus, module registers, ram and external alike; it answers any strobe
module sfa_bus_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [23:0] bus_addr,
	input wire logic bus_strobe,
	input wire logic bus_word,
	output logic [15:0] bus_rdata
);
	// data keyed on the low address byte so each byte lane can be traced
	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'h3c;
	endfunction
	// answer only in the cycle after a strobe; otherwise the lines churn,
	// so a design that samples late cannot pass by luck
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 16'h0000;
		end else if (bus_strobe) begin
			if (bus_word) begin
				bus_rdata <= {pat(bus_addr[7:0]), pat(bus_addr[7:0] + 8'h01)};
			end else begin
				bus_rdata <= {8'ha5, pat(bus_addr[7:0])};
			end
		end else begin
			bus_rdata <= ~bus_rdata;
		end
	end
endmodule
`default_nettype wire

// >>> verif/sfa_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_core_tb_top;
	import sfa_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, op_a = 16'h0000, op_b = 16'h0000;
	logic reg_wr = 1'b0, reg_rd = 1'b0, alu_go = 1'b0, mac_clear = 1'b0, mac_step = 1'b0;
	sfa_op_t alu_op = OP_ADD;
	logic [15:0] alu_result, mul_h = 16'h0000, mul_i = 16'h0000, xfer_out, pc = 16'h0000;
	logic xfer_req = 1'b0, xfer_round = 1'b0, sleep_req = 1'b0, wake_req = 1'b0, clk_halt;
	logic [2:0] irq_level;
	logic fetch_req = 1'b0, acc_req = 1'b0, acc_word = 1'b0, acc_wr = 1'b0;
	logic [19:0] fetch_addr, acc_addr = 20'h00000;
	logic [15:0] acc_wdata = 16'h0000, acc_rdata, bus_wdata, bus_rdata;
	logic acc_done, acc_err, bus_strobe, bus_wr, bus_word, sel_modreg, sel_ram, sel_ext;
	logic [23:0] bus_addr;
	int failures = 0, tests_run = 0;
	// bus operations seen during the current access
	logic [23:0] q_a[$];
	logic [3:0] q_s[$];
	logic [15:0] q_d[$];
	always #25 core_clk = ~core_clk;
	sfa_core sfa_core_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.alu_go(alu_go), .alu_op(alu_op), .op_a(op_a), .op_b(op_b), .alu_result(alu_result),
		.mac_clear(mac_clear), .mac_step(mac_step), .mul_h(mul_h), .mul_i(mul_i),
		.xfer_req(xfer_req), .xfer_round(xfer_round), .xfer_out(xfer_out),
		.sleep_req(sleep_req), .wake_req(wake_req), .clk_halt(clk_halt), .irq_level(irq_level),
		.fetch_req(fetch_req), .pc(pc), .fetch_addr(fetch_addr), .acc_req(acc_req),
		.acc_addr(acc_addr), .acc_word(acc_word), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
		.acc_done(acc_done), .acc_err(acc_err), .acc_rdata(acc_rdata), .bus_addr(bus_addr),
		.bus_strobe(bus_strobe), .bus_wr(bus_wr), .bus_word(bus_word), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .sel_modreg(sel_modreg), .sel_ram(sel_ram), .sel_ext(sel_ext));
	sfa_bus_model sfa_bus_model_inst (.core_clk(core_clk), .reset_n(reset_n),
		.bus_addr(bus_addr), .bus_strobe(bus_strobe), .bus_word(bus_word),
		.bus_rdata(bus_rdata));
	// log every bus operation as {modreg, ram, ext, word}
	always @(posedge core_clk) begin
		if (bus_strobe === 1'b1) begin
			q_a.push_back(bus_addr);
			q_s.push_back({sel_modreg, sel_ram, sel_ext, bus_word});
			q_d.push_back(bus_wdata);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
	task automatic acc(input logic [19:0] a, input logic w, input logic wrt, input logic [15:0] d);
		q_a.delete();
		q_s.delete();
		q_d.delete();
		@(posedge core_clk);
		acc_req <= 1'b1;
		acc_addr <= a;
		acc_word <= w;
		acc_wr <= wrt;
		acc_wdata <= d;
		@(posedge core_clk);
		acc_req <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			if (acc_done === 1'b1) break;
		end
		chk(acc_done, 1'b1);
	endtask
	task automatic t_reset;
		logic [15:0] v;
		rd(CCR_OFS, v);
		chk(v, 16'h00e0);
		rd(SYSCFG_OFS, v);
		chk(v, 16'h8000);
		rd(RAMCTL_OFS, v);
		chk(v, 16'h0000);
		rd(8'h20, v);
		chk(v, 16'h0000);
		chk(irq_level, 3'h7);
	endtask
	// the mask and bank fields drive priority level and fetch address
	task automatic t_bank;
		wr(CCR_OFS, 16'h0065);
		@(posedge core_clk);
		fetch_req <= 1'b1;
		pc <= 16'h1235;
		@(posedge core_clk);
		fetch_req <= 1'b0;
		@(negedge core_clk);
		chk(fetch_addr, 20'h51234);
		chk(irq_level, 3'h3);
	endtask
	task automatic t_sleep;
		@(posedge core_clk) sleep_req <= 1'b1;
		@(posedge core_clk) sleep_req <= 1'b0;
		@(negedge core_clk) chk(clk_halt, 1'b1);
		@(posedge core_clk) wake_req <= 1'b1;
		@(posedge core_clk) wake_req <= 1'b0;
		@(negedge core_clk) chk(clk_halt, 1'b0);
		wr(CCR_OFS, 16'h8065);
		@(posedge core_clk) sleep_req <= 1'b1;
		@(posedge core_clk) sleep_req <= 1'b0;
		@(negedge core_clk) chk(clk_halt, 1'b0);
	endtask
	// one operation, then result and the n z v c nibble; for bcd add only the h flag
	task automatic alu(input sfa_op_t o, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] r, input logic [3:0] f);
		logic [15:0] v;
		@(posedge core_clk);
		alu_go <= 1'b1;
		alu_op <= o;
		op_a <= a;
		op_b <= b;
		@(posedge core_clk);
		alu_go <= 1'b0;
		@(negedge core_clk);
		if (o != OP_BCDADD) chk(alu_result, r);
		rd(CCR_OFS, v);
		if (o == OP_BCDADD) chk(v[H_POS], r[0]);
		else chk(v[11:8], f);
	endtask
	task automatic t_alu;
		alu(OP_ASL, 16'h8001, 16'h0000, 16'h0002, 4'b0011);
		alu(OP_ROL, 16'h0001, 16'h0000, 16'h0003, 4'b0000);
		alu(OP_LSR, 16'h0003, 16'h0000, 16'h0001, 4'b0011);
		alu(OP_ADC, 16'h0001, 16'h0001, 16'h0003, 4'b0000);
		alu(OP_SBC, 16'h0005, 16'h0001, 16'h0004, 4'b0000);
		alu(OP_ROR, 16'h0003, 16'h0000, 16'h0001, 4'b0011);
		alu(OP_ADD, 16'h7fff, 16'h0001, 16'h8000, 4'b1010);
		alu(OP_ADD, 16'hffff, 16'h0001, 16'h0000, 4'b0101);
		alu(OP_SUB, 16'h0005, 16'h0005, 16'h0000, 4'b0100);
		alu(OP_SUB, 16'h0000, 16'h0001, 16'hffff, 4'b1001);
		alu(OP_BCDADD, 16'h0008, 16'h0008, 16'h0001, 4'b0000);
		alu(OP_BCDADD, 16'h0001, 16'h0001, 16'h0000, 4'b0000);
	endtask
	task automatic t_map;
		acc(20'h81230, 1'b1, 1'b0, 16'h0000);
		chk(q_a[0], 24'hf81230);
		chk(q_s[0], 4'b0011);
		chk(acc_err, 1'b0);
		acc(20'hff010, 1'b1, 1'b0, 16'h0000);
		chk(q_s[0][3], 1'b1);
		acc(20'h00800, 1'b1, 1'b0, 16'h0000);
		chk(q_s[0], 4'b0011);
		wr(RAMCTL_OFS, 16'h0081);
		acc(20'h00800, 1'b1, 1'b0, 16'h0000);
		chk(q_s[0], 4'b0101);
		wr(SYSCFG_OFS, 16'h0000);
		wr(SYSCFG_OFS, 16'h8000);
		acc(20'hff010, 1'b1, 1'b0, 16'h0000);
		chk(q_s[0], 4'b0011);
	endtask
	// misaligned words split into two byte operations, high byte first
	task automatic t_odd;
		acc(20'h01001, 1'b1, 1'b0, 16'h0000);
		chk(q_a.size(), 2);
		chk(q_a[1], 24'h001002);
		chk(acc_rdata, 16'h3d3e);
		acc(20'h01001, 1'b1, 1'b1, 16'hbeef);
		chk({q_d[0][7:0], q_d[1][7:0]}, 16'hbeef);
		acc(20'h01002, 1'b1, 1'b0, 16'h0000);
		chk(q_a.size(), 1);
		chk(acc_rdata, 16'h3e3f);
	endtask
	task automatic mac(input logic [15:0] h, input int n);
		repeat (n) begin
			@(posedge core_clk);
			mac_step <= 1'b1;
			mul_h <= h;
			mul_i <= h;
			@(posedge core_clk) mac_step <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
		xfer_req <= 1'b1;
		@(posedge core_clk) xfer_req <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic t_mac;
		logic [15:0] v;
		@(posedge core_clk) mac_clear <= 1'b1;
		@(posedge core_clk) mac_clear <= 1'b0;
		// a small square leaves bit 15 set, so the rounded transfer adds one
		xfer_round <= 1'b1;
		mac(16'h00b5, 1);
		chk(xfer_out, 16'h0001);
		xfer_round <= 1'b0;
		mac(16'h4000, 1);
		chk(xfer_out, 16'h2000);
		wr(CCR_OFS, 16'h00f0);
		@(posedge core_clk) mac_clear <= 1'b1;
		@(posedge core_clk) mac_clear <= 1'b0;
		mac(16'h8000, 1);
		chk(xfer_out, SAT_POS_VAL);
		rd(CCR_OFS, v);
		chk(v[EV_POS], 1'b1);
		mac(16'h8000, 15);
		rd(CCR_OFS, v);
		chk(v[MV_POS], 1'b1);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_bank();
		t_sleep();
		t_alu();
		t_map();
		t_odd();
		t_mac();
		summarize();
	end
	// the whole sequence takes well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
